// ===== hw/bitmap_state_command_decoder.sv
// per-handle bitmap drawing state fed by display-list command words
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bitmap_state_command_decoder (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register bus, write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// register bus, read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// drawing state of the current handle, and the transform coefficient shared by all handles
	output logic [11:0] drawWidth,
	output logic [11:0] drawHeight,
	output logic filterBilinear,
	output logic wrapRepeatX,
	output logic wrapRepeatY,
	output logic [1:0] layoutPitchHi,
	output logic [1:0] layoutHeightHi,
	output logic fetchFlash,
	output logic [27:0] fetchAddr,
	output logic flashCopyNeeded,
	output logic [11:0] swizzleSel,
	output logic [16:0] coefA,
	output logic coefAPrec
);
	bsc_reg_if rif();
	bsc_cmd_if cif();

	bsc_axil_slave u_bus (
		.core_clk(core_clk),
		.rst(rst),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.r(rif.slave)
	);

	bsc_cmd_decode u_dec (
		.c(cif.dec)
	);

	function automatic logic isMapped(input logic [7:0] a);
		return a <= `BSC_A_LAST;
	endfunction

	function automatic logic [11:0] dimPixels(input logic [1:0] hi, input logic [8:0] lo);
		logic [11:0] full;
		full = {1'b0, hi, lo};
		return (full == '0) ? `BSC_DIM_FULL : full;
	endfunction

	function automatic logic [27:0] fetchByte(input logic flash, input logic [22:0] a);
		logic [27:0] wide;
		wide = {5'h00, a};
		return flash ? (wide << `BSC_FLASH_SHIFT) : wide;
	endfunction

	bsc_pkg::handle_s hs_reg [`BSC_HANDLES];
	bsc_pkg::handle_s hs_next [`BSC_HANDLES];
	bsc_pkg::handle_s curHs;
	bsc_pkg::cmd_s dc;
	logic [4:0] handle_reg, handle_next;
	logic [16:0] coef_reg, coef_next, savedCoef_reg, savedCoef_next;
	logic prec_reg, prec_next, savedPrec_reg, savedPrec_next;
	logic [7:0] lastOp_reg, lastOp_next;
	logic lastKnown_reg, lastKnown_next;
	logic cmdExec, ctxSave, ctxRestore, byte0;
	logic [11:0] drawWidth_next, drawHeight_next, swizzleSel_next;
	logic [27:0] fetchAddr_next;

	assign cif.word = rif.wrData;
	assign dc = cif.cmd;
	assign curHs = hs_reg[handle_reg];
	assign byte0 = rif.wrPulse && rif.wrStrb[0];
	// a command only runs as a whole word; a partial write would leave fields undefined
	assign cmdExec = rif.wrPulse && rif.wrAddr == `BSC_A_CMD && rif.wrStrb == `BSC_STRB_ALL;
	assign ctxSave = byte0 && rif.wrAddr == `BSC_A_CONTEXT && rif.wrData[`BSC_CTX_SAVE];
	assign ctxRestore = byte0 && rif.wrAddr == `BSC_A_CONTEXT && rif.wrData[`BSC_CTX_RESTORE];
	assign rif.wrHit = isMapped(rif.wrAddr);
	assign rif.rdHit = isMapped(rif.rdAddr);

	always_comb begin
		hs_next = hs_reg;
		handle_next = handle_reg;
		coef_next = coef_reg;
		prec_next = prec_reg;
		savedCoef_next = savedCoef_reg;
		savedPrec_next = savedPrec_reg;
		lastOp_next = lastOp_reg;
		lastKnown_next = lastKnown_reg;
		if (byte0 && rif.wrAddr == `BSC_A_HANDLE) begin
			handle_next = rif.wrData[`BSC_HANDLE_HI:0];
		end
		if (byte0 && rif.wrAddr == `BSC_A_FORMAT) begin
			hs_next[handle_reg].fmt = rif.wrData[`BSC_FMT_CODE_HI:0];
			hs_next[handle_reg].astc = rif.wrData[`BSC_FMT_ASTC_BIT];
		end
		// save and restore in one write swap the live and saved coefficient
		if (ctxSave) begin
			savedCoef_next = coef_reg;
			savedPrec_next = prec_reg;
		end
		if (ctxRestore) begin
			coef_next = savedCoef_reg;
			prec_next = savedPrec_reg;
		end
		if (cmdExec) begin
			lastOp_next = dc.op;
			lastKnown_next = dc.kind != bsc_pkg::K_NONE;
			// every per-handle write below lands on the current handle only
			unique case (dc.kind)
				bsc_pkg::K_LAYH: begin
					hs_next[handle_reg].layP = dc.extW;
					hs_next[handle_reg].layH = dc.extH;
				end
				bsc_pkg::K_SIZE: begin
					hs_next[handle_reg].filter = dc.filter;
					hs_next[handle_reg].wrapX = dc.wrapX;
					hs_next[handle_reg].wrapY = dc.wrapY;
					hs_next[handle_reg].wLo = dc.wLo;
					hs_next[handle_reg].hLo = dc.hLo;
				end
				bsc_pkg::K_SIZEH: begin
					hs_next[handle_reg].szW = dc.extW;
					hs_next[handle_reg].szH = dc.extH;
				end
				bsc_pkg::K_SOURCE: begin
					hs_next[handle_reg].flash = dc.flash;
					hs_next[handle_reg].addr = dc.addr;
				end
				bsc_pkg::K_SWZ: begin
					hs_next[handle_reg].swz = dc.swz;
				end
				bsc_pkg::K_XFORM: begin
					coef_next = dc.coef;
					prec_next = dc.prec;
				end
				bsc_pkg::K_NONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `BSC_HANDLES; i++) begin
				hs_reg[i] <= bsc_pkg::HS_INIT;
			end
			handle_reg <= '0;
			coef_reg <= `BSC_COEF_A_INIT;
			prec_reg <= 1'b0;
			savedCoef_reg <= `BSC_COEF_A_INIT;
			savedPrec_reg <= 1'b0;
			lastOp_reg <= '0;
			lastKnown_reg <= 1'b0;
		end else begin
			hs_reg <= hs_next;
			handle_reg <= handle_next;
			coef_reg <= coef_next;
			prec_reg <= prec_next;
			savedCoef_reg <= savedCoef_next;
			savedPrec_reg <= savedPrec_next;
			lastOp_reg <= lastOp_next;
			lastKnown_reg <= lastKnown_next;
		end
	end

	// drawing outputs follow the current handle with one cycle of lag
	always_comb begin
		drawWidth_next = dimPixels(curHs.szW, curHs.wLo);
		drawHeight_next = dimPixels(curHs.szH, curHs.hLo);
		fetchAddr_next = fetchByte(curHs.flash, curHs.addr);
		// swizzle is held but ignored unless the layout uses the extended format
		swizzleSel_next = (curHs.fmt == `BSC_EXT_FORMAT) ? curHs.swz : `BSC_SWZ_DEFAULT;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			drawWidth <= `BSC_DIM_FULL;
			drawHeight <= `BSC_DIM_FULL;
			filterBilinear <= 1'b0;
			wrapRepeatX <= 1'b0;
			wrapRepeatY <= 1'b0;
			layoutPitchHi <= '0;
			layoutHeightHi <= '0;
			fetchFlash <= 1'b0;
			fetchAddr <= '0;
			flashCopyNeeded <= 1'b0;
			swizzleSel <= `BSC_SWZ_DEFAULT;
			coefA <= `BSC_COEF_A_INIT;
			coefAPrec <= 1'b0;
		end else begin
			drawWidth <= drawWidth_next;
			drawHeight <= drawHeight_next;
			filterBilinear <= curHs.filter;
			wrapRepeatX <= curHs.wrapX;
			wrapRepeatY <= curHs.wrapY;
			layoutPitchHi <= curHs.layP;
			layoutHeightHi <= curHs.layH;
			fetchFlash <= curHs.flash;
			fetchAddr <= fetchAddr_next;
			flashCopyNeeded <= curHs.flash && !curHs.astc;
			swizzleSel <= swizzleSel_next;
			coefA <= coef_reg;
			coefAPrec <= prec_reg;
		end
	end

	always_comb begin
		case (rif.rdAddr)
			`BSC_A_HANDLE: rif.rdData = {27'h0, handle_reg};
			`BSC_A_FORMAT: rif.rdData = {23'h0, curHs.astc, 3'h0, curHs.fmt};
			`BSC_A_SIZE: rif.rdData = {5'h00, wrapRepeatY, wrapRepeatX, filterBilinear,
				drawHeight, drawWidth};
			`BSC_A_SOURCE: rif.rdData = {fetchFlash, flashCopyNeeded, 2'h0, fetchAddr};
			`BSC_A_EXT: rif.rdData = {24'h0, curHs.szW, curHs.szH, layoutPitchHi, layoutHeightHi};
			`BSC_A_SWZ: rif.rdData = {20'h0, swizzleSel};
			`BSC_A_XFORM: rif.rdData = {14'h0, coefAPrec, coefA};
			`BSC_A_LAST: rif.rdData = {23'h0, lastKnown_reg, lastOp_reg};
			default: rif.rdData = '0;
		endcase
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence runs(bsc_pkg::kind_e k);
		cmdExec && dc.kind == k;
	endsequence

	chk_layout_ext_bits: assert property (
		runs(bsc_pkg::K_LAYH) |-> ##2 (layoutPitchHi == $past(dc.extW, 2)
			&& layoutHeightHi == $past(dc.extH, 2)))
		else $error("layout extension bits not applied");
	chk_size_modes: assert property (
		runs(bsc_pkg::K_SIZE) |-> ##2 (filterBilinear == $past(dc.filter, 2)
			&& wrapRepeatX == $past(dc.wrapX, 2) && wrapRepeatY == $past(dc.wrapY, 2)))
		else $error("size command modes not applied");
	chk_width_full: assert property (
		runs(bsc_pkg::K_SIZE) ##0 (dc.wLo == '0 && curHs.szW == '0)
			|-> ##2 drawWidth == `BSC_DIM_FULL)
		else $error("zero width did not mean full size");
	chk_size_ext_bits: assert property (
		runs(bsc_pkg::K_SIZEH) ##0 (curHs.wLo != '0)
			|-> ##2 drawWidth[`BSC_DIM_EXT_HI:`BSC_DIM_EXT_LO] == $past(dc.extW, 2))
		else $error("size extension width bits not applied");
	chk_source_map: assert property (
		runs(bsc_pkg::K_SOURCE) |-> ##2 (fetchFlash == $past(dc.flash, 2)
			&& fetchAddr == fetchByte($past(dc.flash, 2), $past(dc.addr, 2))))
		else $error("source address mapped wrongly");
	chk_flash_copy: assert property (
		fetchFlash && !flashCopyNeeded |-> $past(curHs.astc))
		else $error("flash render allowed for non-compressed format");
	chk_swizzle_gate: assert property (
		$past(curHs.fmt) != `BSC_EXT_FORMAT |-> swizzleSel == `BSC_SWZ_DEFAULT)
		else $error("swizzle used outside extended format");
	chk_coef_load: assert property (
		runs(bsc_pkg::K_XFORM) |-> ##2 (coefA == $past(dc.coef, 2)
			&& coefAPrec == $past(dc.prec, 2)))
		else $error("coefficient command not applied");
	chk_ctx_restore: assert property (
		ctxRestore |-> ##2 (coefA == $past(savedCoef_reg, 2)
			&& coefAPrec == $past(savedPrec_reg, 2)))
		else $error("context restore lost coefficient");
endmodule

// ===== hw/bsc_axil_slave.sv
// axi4-lite slave front end for the decoder registers
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_axil_slave (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	bsc_reg_if.slave r
);
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next, rData_reg, rData_next;
	logic [3:0] wStrb_reg, wStrb_next;
	logic bValid_reg, bValid_next, rValid_reg, rValid_next;
	logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;

	// a new write is held off until its response is gone, so at most one is under way
	assign awready = !awHeld_reg && !bValid_reg;
	assign wready = !wHeld_reg && !bValid_reg;
	assign arready = !rValid_reg;
	assign r.wrPulse = awHeld_reg && wHeld_reg && !bValid_reg;
	assign r.wrAddr = {awAddr_reg[7:2], 2'h0};
	assign r.wrData = wData_reg;
	assign r.wrStrb = wStrb_reg;
	assign r.rdAddr = {araddr[7:2], 2'h0};

	always_comb begin
		awHeld_next = awHeld_reg;
		awAddr_next = awAddr_reg;
		wHeld_next = wHeld_reg;
		wData_next = wData_reg;
		wStrb_next = wStrb_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		rValid_next = rValid_reg;
		rData_next = rData_reg;
		rResp_next = rResp_reg;
		if (awvalid && awready) begin
			awHeld_next = 1'b1;
			awAddr_next = awaddr;
		end
		if (wvalid && wready) begin
			wHeld_next = 1'b1;
			wData_next = wdata;
			wStrb_next = wstrb;
		end
		if (r.wrPulse) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bValid_next = 1'b1;
			bResp_next = r.wrHit ? `BSC_RESP_OKAY : `BSC_RESP_SLVERR;
		end else if (bValid_reg && bready) begin
			bValid_next = 1'b0;
		end
		if (arvalid && arready) begin
			rValid_next = 1'b1;
			rData_next = r.rdHit ? r.rdData : '0;
			rResp_next = r.rdHit ? `BSC_RESP_OKAY : `BSC_RESP_SLVERR;
		end else if (rValid_reg && rready) begin
			rValid_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wHeld_reg <= 1'b0;
			wData_reg <= '0;
			wStrb_reg <= '0;
			bValid_reg <= 1'b0;
			bResp_reg <= '0;
			rValid_reg <= 1'b0;
			rData_reg <= '0;
			rResp_reg <= '0;
		end else begin
			awHeld_reg <= awHeld_next;
			awAddr_reg <= awAddr_next;
			wHeld_reg <= wHeld_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			rValid_reg <= rValid_next;
			rData_reg <= rData_next;
			rResp_reg <= rResp_next;
		end
	end

	assign bvalid = bValid_reg;
	assign bresp = bResp_reg;
	assign rvalid = rValid_reg;
	assign rdata = rData_reg;
	assign rresp = rResp_reg;
endmodule

// ===== hw/bsc_cmd_decode.sv
// splits one display-list word into its command kind and fields
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_cmd_decode (
	// word in, fields out
	bsc_cmd_if.dec c
);
	bsc_pkg::cmd_s d;

	// reserved bits between opcode and fields are simply never looked at
	always_comb begin
		d = '0;
		d.op = c.word[`BSC_OP_HI:`BSC_OP_LO];
		d.filter = c.word[`BSC_SZ_FILTER];
		d.wrapX = c.word[`BSC_SZ_WRAPX];
		d.wrapY = c.word[`BSC_SZ_WRAPY];
		d.wLo = c.word[`BSC_SZ_W_HI:`BSC_SZ_W_LO];
		d.hLo = c.word[`BSC_SZ_H_HI:`BSC_SZ_H_LO];
		d.extW = c.word[`BSC_EXT_W_HI:`BSC_EXT_W_LO];
		d.extH = c.word[`BSC_EXT_H_HI:`BSC_EXT_H_LO];
		d.flash = c.word[`BSC_SRC_FLASH];
		d.addr = c.word[`BSC_SRC_ADDR_HI:0];
		d.swz = c.word[`BSC_SWZ_HI:0];
		d.prec = c.word[`BSC_XA_PREC];
		d.coef = c.word[`BSC_XA_V_HI:0];
		case (d.op)
			`BSC_OP_SOURCE: d.kind = bsc_pkg::K_SOURCE;
			`BSC_OP_SIZE: d.kind = bsc_pkg::K_SIZE;
			`BSC_OP_XFORM_A: d.kind = bsc_pkg::K_XFORM;
			`BSC_OP_LAYOUT_H: d.kind = bsc_pkg::K_LAYH;
			`BSC_OP_SIZE_H: d.kind = bsc_pkg::K_SIZEH;
			`BSC_OP_SWIZZLE: d.kind = bsc_pkg::K_SWZ;
			default: d.kind = bsc_pkg::K_NONE;
		endcase
	end

	assign c.cmd = d;
endmodule

// ===== hw/bsc_defs.svh
// shared constants of the bitmap state command decoder
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
`define BSC_OP_HI 31
`define BSC_OP_LO 24
`define BSC_OP_SOURCE 8'h01
`define BSC_OP_SIZE 8'h08
`define BSC_OP_XFORM_A 8'h15
`define BSC_OP_LAYOUT_H 8'h28
`define BSC_OP_SIZE_H 8'h29
`define BSC_OP_SWIZZLE 8'h2f
`define BSC_SZ_FILTER 20
`define BSC_SZ_WRAPX 19
`define BSC_SZ_WRAPY 18
`define BSC_SZ_W_HI 17
`define BSC_SZ_W_LO 9
`define BSC_SZ_H_HI 8
`define BSC_SZ_H_LO 0
`define BSC_EXT_W_HI 3
`define BSC_EXT_W_LO 2
`define BSC_EXT_H_HI 1
`define BSC_EXT_H_LO 0
`define BSC_SRC_FLASH 23
`define BSC_SRC_ADDR_HI 22
`define BSC_SWZ_HI 11
`define BSC_XA_PREC 17
`define BSC_XA_V_HI 16
`define BSC_FLASH_SHIFT 5
`define BSC_DIM_FULL 12'h800
`define BSC_DIM_EXT_HI 10
`define BSC_DIM_EXT_LO 9
`define BSC_SWZ_DEFAULT 12'h4e5
`define BSC_COEF_A_INIT 17'h00100
`define BSC_EXT_FORMAT 5'h1f
`define BSC_HANDLES 32
`define BSC_A_CMD 8'h00
`define BSC_A_HANDLE 8'h04
`define BSC_A_FORMAT 8'h08
`define BSC_A_CONTEXT 8'h0c
`define BSC_A_SIZE 8'h10
`define BSC_A_SOURCE 8'h14
`define BSC_A_EXT 8'h18
`define BSC_A_SWZ 8'h1c
`define BSC_A_XFORM 8'h20
`define BSC_A_LAST 8'h24
`define BSC_FMT_ASTC_BIT 8
`define BSC_FMT_CODE_HI 4
`define BSC_HANDLE_HI 4
`define BSC_CTX_SAVE 0
`define BSC_CTX_RESTORE 1
`define BSC_STRB_ALL 4'hf
`define BSC_RESP_OKAY 2'h0
`define BSC_RESP_SLVERR 2'h2
`endif

// ===== hw/bsc_links.sv
// carriers between the bus slave, the decoder and the state store
`timescale 1ns/1ps
interface bsc_reg_if;
	logic wrPulse;
	logic [7:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wrHit;
	logic [7:0] rdAddr;
	logic [31:0] rdData;
	logic rdHit;
	modport slave(output wrPulse, wrAddr, wrData, wrStrb, rdAddr, input wrHit, rdData, rdHit);
	modport regs(input wrPulse, wrAddr, wrData, wrStrb, rdAddr, output wrHit, rdData, rdHit);
endinterface

interface bsc_cmd_if;
	logic [31:0] word;
	bsc_pkg::cmd_s cmd;
	modport dec(input word, output cmd);
	modport core(output word, input cmd);
endinterface

// ===== hw/bsc_pkg.sv
// types of the bitmap state command decoder
`include "bsc_defs.svh"
package bsc_pkg;
	typedef enum logic [6:0] {
		K_NONE = 7'b0000001,
		K_SOURCE = 7'b0000010,
		K_SIZE = 7'b0000100,
		K_XFORM = 7'b0001000,
		K_LAYH = 7'b0010000,
		K_SIZEH = 7'b0100000,
		K_SWZ = 7'b1000000
	} kind_e;
	typedef struct packed {
		kind_e kind;
		logic [7:0] op;
		logic filter;
		logic wrapX;
		logic wrapY;
		logic [8:0] wLo;
		logic [8:0] hLo;
		logic [1:0] extW;
		logic [1:0] extH;
		logic flash;
		logic [22:0] addr;
		logic [11:0] swz;
		logic prec;
		logic [16:0] coef;
	} cmd_s;
	typedef struct packed {
		logic [4:0] fmt;
		logic astc;
		logic filter;
		logic wrapX;
		logic wrapY;
		logic [8:0] wLo;
		logic [8:0] hLo;
		logic [1:0] szW;
		logic [1:0] szH;
		logic [1:0] layP;
		logic [1:0] layH;
		logic flash;
		logic [22:0] addr;
		logic [11:0] swz;
	} handle_s;
	localparam handle_s HS_INIT = '{swz: `BSC_SWZ_DEFAULT, default: '0};
endpackage

// ===== tb/bitmap_state_command_decoder_bench.sv
// self-checking bench of the bitmap state command decoder
`timescale 1ns/1ps
module bitmap_state_command_decoder_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, layoutPitchHi, layoutHeightHi;
	logic [11:0] drawWidth, drawHeight, swizzleSel;
	logic filterBilinear, wrapRepeatX, wrapRepeatY, fetchFlash, flashCopyNeeded, coefAPrec;
	logic [27:0] fetchAddr;
	logic [16:0] coefA;
	int failures = 0;
	int checks = 0;
	int seed = 32'h7366;
	always #5 core_clk = ~core_clk;
	bitmap_state_command_decoder dut (.core_clk(core_clk), .rst(rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .drawWidth(drawWidth), .drawHeight(drawHeight),
		.filterBilinear(filterBilinear), .wrapRepeatX(wrapRepeatX), .wrapRepeatY(wrapRepeatY),
		.layoutPitchHi(layoutPitchHi), .layoutHeightHi(layoutHeightHi), .fetchFlash(fetchFlash),
		.fetchAddr(fetchAddr), .flashCopyNeeded(flashCopyNeeded), .swizzleSel(swizzleSel),
		.coefA(coefA), .coefAPrec(coefAPrec));
	dl_host_model host (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	task automatic wrap_up();
		if (failures == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		host.wr(a, d, 4'hf, r);
		if (host.hangs != 0) begin
			failures++;
			wrap_up();
		end
		check({30'h0, r}, {30'h0, e});
		// outputs follow one cycle after the response
		repeat (2) @(posedge core_clk);
	endtask
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		if (host.hangs != 0) begin
			failures++;
			wrap_up();
		end
		check(d, e);
		// only offsets past the last mapped word answer with an error
		check({30'h0, r}, (a > 8'h24) ? 32'h2 : 32'h0);
	endtask
	function automatic logic [11:0] eff_dim(input logic [1:0] hi, input logic [8:0] lo);
		return (hi == 2'h0 && lo == 9'h0) ? 12'h800 : {1'b0, hi, lo};
	endfunction
	logic [31:0] rnd, ext, lay, old;
	logic [11:0] expW, expH, s;
	logic astc;
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		expect_rd(8'h10, 32'h00800800);
		expect_rd(8'h18, 32'h0);
		expect_rd(8'h1c, 32'h4e5);
		expect_rd(8'h20, 32'h100);
		// size, size and layout extensions with random reserved bits
		for (int i = 0; i < 12; i++) begin
			host.lag = i % 3;
			rnd = $random(seed);
			ext = $random(seed);
			lay = $random(seed);
			if (i < 3) rnd[17:0] = 18'h0;
			if (i < 2) ext[3:0] = 4'h0;
			// a repeated axis gets a power-of-two layout dimension
			if (rnd[19]) lay[3:2] = {lay[2], !lay[2]};
			if (rnd[18]) lay[1:0] = {lay[0], !lay[0]};
			wreg(8'h00, {8'h29, ext[23:0]}, 2'h0);
			wreg(8'h00, {8'h28, lay[23:0]}, 2'h0);
			wreg(8'h00, {8'h08, rnd[23:0]}, 2'h0);
			expW = eff_dim(ext[3:2], rnd[17:9]);
			expH = eff_dim(ext[1:0], rnd[8:0]);
			expect_rd(8'h10, {5'h0, rnd[18], rnd[19], rnd[20], expH, expW});
			check({8'h0, drawHeight, drawWidth}, {8'h0, expH, expW});
			check({29'h0, filterBilinear, wrapRepeatX, wrapRepeatY}, {29'h0, rnd[20:18]});
			expect_rd(8'h18, {24'h0, ext[3:0], lay[3:0]});
			check({28'h0, layoutPitchHi, layoutHeightHi}, {28'h0, lay[3:0]});
		end
		// source in ram or flash, compressed or not
		for (int i = 0; i < 8; i++) begin
			rnd = (i == 7) ? 32'hffffff : $random(seed);
			astc = (i % 4) < 2;
			rnd[23] = i[0] | (i == 7);
			if (!rnd[23]) rnd[0] = 1'b0; // ram sources even and masked to 23 bits
			wreg(8'h08, {23'h0, astc, 3'h0, 5'h07}, 2'h0);
			wreg(8'h00, {8'h01, rnd[23:0]}, 2'h0);
			lay = rnd[23] ? {4'h0, rnd[22:0], 5'h0} : {9'h0, rnd[22:0]};
			expect_rd(8'h14, {rnd[23], rnd[23] & !astc, 2'h0, lay[27:0]});
			check({3'h0, fetchFlash, fetchAddr}, {3'h0, rnd[23], lay[27:0]});
		end
		// select codes 0 to 5 on every channel under the extended format
		wreg(8'h08, 32'h1f, 2'h0);
		for (int c = 0; c < 6; c++) begin
			s = {3'(c), 3'((c + 1) % 6), 3'((c + 2) % 6), 3'((c + 3) % 6)};
			wreg(8'h00, {8'h2f, 12'h0, s}, 2'h0);
			expect_rd(8'h1c, {20'h0, s});
			check({20'h0, swizzleSel}, {20'h0, s});
		end
		wreg(8'h08, 32'h07, 2'h0);
		check({20'h0, swizzleSel}, 32'h4e5);
		// coefficient with context save and restore
		old = $random(seed);
		wreg(8'h00, {8'h15, old[23:0]}, 2'h0);
		expect_rd(8'h20, {14'h0, old[17:0]});
		check({14'h0, coefAPrec, coefA}, {14'h0, old[17:0]});
		wreg(8'h0c, 32'h1, 2'h0);
		rnd = ~old;
		wreg(8'h00, {8'h15, rnd[23:0]}, 2'h0);
		expect_rd(8'h20, {14'h0, rnd[17:0]});
		wreg(8'h0c, 32'h2, 2'h0);
		expect_rd(8'h20, {14'h0, old[17:0]});
		// save and restore together swap live and saved values
		wreg(8'h00, {8'h15, rnd[23:0]}, 2'h0);
		wreg(8'h0c, 32'h3, 2'h0);
		expect_rd(8'h20, {14'h0, old[17:0]});
		wreg(8'h0c, 32'h2, 2'h0);
		expect_rd(8'h20, {14'h0, rnd[17:0]});
		check({14'h0, coefAPrec, coefA}, {14'h0, rnd[17:0]});
		// settings stay with the handle that was current
		wreg(8'h04, 32'h1, 2'h0);
		wreg(8'h00, {8'h08, 24'h000a03}, 2'h0);
		wreg(8'h04, 32'h2, 2'h0);
		expect_rd(8'h10, 32'h00800800);
		wreg(8'h04, 32'h1, 2'h0);
		expect_rd(8'h10, 32'h00003005);
		// unknown opcode and unmapped offsets
		wreg(8'h00, 32'h3f000000, 2'h0);
		expect_rd(8'h24, 32'h3f);
		wreg(8'h40, 32'h1, 2'h2);
		expect_rd(8'h40, 32'h0);
		// a second reset in mid-run brings back the initial state
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		expect_rd(8'h18, 32'h0);
		expect_rd(8'h20, 32'h100);
		wrap_up();
	end
endmodule

// ===== tb/dl_host_model.sv
// bus master model of the host that writes display-list words
`timescale 1ns/1ps
module dl_host_model (
	// clock
	input wire logic core_clk,
	// write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	int hangs = 0;
	int lag = 0;
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	// address and data are offered together, taken in either order
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		logic aw;
		logic w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w) && n < 50) begin
			@(posedge core_clk);
			n++;
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		// a slow host leaves the response waiting
		repeat (lag) @(posedge core_clk);
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		r = bresp;
		bready <= 1'b0;
		if (n >= 100) hangs++;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		araddr <= ~a;
		repeat (lag) @(posedge core_clk);
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 100) hangs++;
	endtask
endmodule
